// ===== hdl/camera_digital_io_lines.sv
`timescale 1ns/1ns
`default_nettype none

module camera_digital_io_lines
	import gpio_lines_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// register bus
	input  wire apb_req_s    apb_req,
	output apb_rsp_s         apb_rsp,
	// internal signals offered as line sources
	input  wire int_src_s    int_src,
	// connector lines
	input  wire logic [3:0]  line_in,
	output logic      [3:0]  line_out,
	output logic      [3:0]  line_oe,
	output logic      [3:0]  rail_enable,
	// sensor side
	output logic      [1:0]  exposure_mode
);

	state_s q_r;
	state_s q_nxt;

	logic setup;
	logic access;
	logic wr;

	function automatic logic addr_ok(input logic [7:0] a);
		case (a)
			ADDR_LINE_SEL, ADDR_LINE_DIR, ADDR_RAIL_EN, ADDR_INVERT,
			ADDR_LEVEL, ADDR_ALL_LEVELS, ADDR_FILT_KIND,
			ADDR_FILT_WIDTH, ADDR_OUT_SRC, ADDR_CIRCUIT,
			ADDR_EXP_MODE, ADDR_USER_SEL, ADDR_USER_VAL,
			ADDR_USER_ALL: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	function automatic logic src_pick(
		input logic [4:0] s,
		input logic [3:0] lvl,
		input logic [3:0] uout,
		input int_src_s   is
	);
		case (s)
			SRC_LINE0:    src_pick = lvl[0];
			SRC_LINE1:    src_pick = lvl[1];
			SRC_LINE2:    src_pick = lvl[2];
			SRC_LINE3:    src_pick = lvl[3];
			SRC_USER0:    src_pick = uout[0];
			SRC_USER1:    src_pick = uout[1];
			SRC_USER2:    src_pick = uout[2];
			SRC_USER3:    src_pick = uout[3];
			SRC_CNT0_ACT: src_pick = is.counter_active[0];
			SRC_CNT1_ACT: src_pick = is.counter_active[1];
			SRC_LOGIC0:   src_pick = is.logic_block_out[0];
			SRC_LOGIC1:   src_pick = is.logic_block_out[1];
			SRC_EXPOSING: src_pick = is.exposing;
			SRC_TRIG_RDY: src_pick = is.trigger_ready;
			SRC_PPS:      src_pick = is.pps;
			SRC_SERIAL0:  src_pick = is.serial_tx;
			default:      src_pick = 1'b0;
		endcase
	endfunction : src_pick

	function automatic logic [31:0] rd_mux(
		input state_s     s,
		input logic [7:0] a
	);
		logic [1:0] n;
		n = s.sel;
		case (a)
			ADDR_LINE_SEL:   rd_mux = {30'h0, s.sel};
			ADDR_LINE_DIR:   rd_mux = {31'h0, s.dir[n]};
			ADDR_RAIL_EN:    rd_mux = {31'h0, s.rail[n]};
			ADDR_INVERT:     rd_mux = {31'h0, s.inv[n]};
			ADDR_LEVEL:      rd_mux = {31'h0, s.lvl[n]};
			ADDR_ALL_LEVELS: rd_mux = {28'h0, s.lvl};
			ADDR_FILT_KIND:  rd_mux = {31'h0, s.fkind[n]};
			ADDR_FILT_WIDTH: rd_mux = s.fkind[n] ? s.wdb[n] : s.wdg[n];
			ADDR_OUT_SRC:    rd_mux = {27'h0, s.src[n]};
			ADDR_CIRCUIT:    rd_mux = {30'h0, CIRCUIT_MAP[2*n +: 2]};
			ADDR_EXP_MODE:   rd_mux = {30'h0, s.exp_mode};
			ADDR_USER_SEL:   rd_mux = {30'h0, s.usel};
			ADDR_USER_VAL:   rd_mux = {31'h0, s.uout[s.usel]};
			ADDR_USER_ALL:   rd_mux = {28'h0, s.uout};
			default:         rd_mux = 32'h0000_0000;
		endcase
	endfunction : rd_mux

	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;
	assign wr     = access & apb_req.pwrite & addr_ok(apb_req.paddr);

	// zero wait states; read data was captured in the setup cycle
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = access & ~addr_ok(apb_req.paddr);
	assign apb_rsp.prdata  = q_r.rdata;

	assign line_out      = q_r.pin_val;
	assign line_oe       = q_r.pin_oe;
	assign rail_enable   = q_r.rail_on;
	assign exposure_mode = q_r.exp_mode;

	always_comb begin
		logic [1:0]       n;
		logic [31:0]      d;
		logic [CYC_W-1:0] cg;
		logic [CYC_W-1:0] cb;
		logic             v;
		n  = q_r.sel;
		d  = apb_req.pwdata;
		cg = '0;
		cb = '0;
		v  = 1'b0;
		q_nxt = q_r;

		// register writes take effect at the access edge
		if (wr) begin
			case (apb_req.paddr)
				ADDR_LINE_SEL:  q_nxt.sel = d[1:0];
				ADDR_LINE_DIR:  q_nxt.dir[n] = d[0];
				ADDR_RAIL_EN:   q_nxt.rail[n] = d[0] & RAIL_CAPABLE[n];
				ADDR_INVERT:    q_nxt.inv[n] = d[0];
				ADDR_FILT_KIND: q_nxt.fkind[n] = d[0];
				ADDR_FILT_WIDTH: begin
					if (q_r.fkind[n] == FILT_DEBOUNCE)
						q_nxt.wdb[n] = d;
					else
						q_nxt.wdg[n] = d;
				end
				ADDR_OUT_SRC:   q_nxt.src[n] = d[4:0];
				ADDR_EXP_MODE:  q_nxt.exp_mode = d[1:0];
				ADDR_USER_SEL:  q_nxt.usel = d[1:0];
				ADDR_USER_VAL:  q_nxt.uout[q_r.usel] = d[0];
				ADDR_USER_ALL:  q_nxt.uout = d[3:0];
				default: ;
			endcase
		end

		// reads sample the line state at the setup cycle only
		if (setup)
			q_nxt.rdata = rd_mux(q_r, apb_req.paddr);

		// pins are asynchronous; accept a level once two stages agree
		q_nxt.s1 = line_in;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		for (int i = 0; i < NLINES; i++) begin
			if (q_r.s2[i] == q_r.s3[i])
				q_nxt.syn[i] = q_r.s3[i];
		end

		for (int i = 0; i < NLINES; i++) begin
			cg = us_to_cyc(q_r.wdg[i]);
			cb = us_to_cyc(q_r.wdb[i]);

			// deglitch: new level must hold for the full width
			if (q_r.syn[i] == q_r.dg[i]) begin
				q_nxt.dgc[i] = '0;
			end else if (q_r.dgc[i] + 1'b1 >= cg) begin
				q_nxt.dg[i]  = q_r.syn[i];
				q_nxt.dgc[i] = '0;
			end else begin
				q_nxt.dgc[i] = q_r.dgc[i] + 1'b1;
			end

			// debounce sits behind deglitch; first edge passes at once
			if (q_r.dbc[i] != '0) begin
				q_nxt.dbc[i] = q_r.dbc[i] - 1'b1;
			end else if (q_r.dg[i] != q_r.db[i]) begin
				q_nxt.db[i]  = q_r.dg[i];
				q_nxt.dbc[i] = cb;
			end

			// output path; source only matters in output direction
			v = src_pick(q_r.src[i], q_r.lvl, q_r.uout, int_src)
				^ q_r.inv[i];
			if (q_r.dir[i] == DIR_OUTPUT) begin
				q_nxt.lvl[i] = v;
				if (CIRCUIT_MAP[2*i +: 2] == CT_OPEN_DRAIN) begin
					// can only sink; high comes from the external pull-up
					q_nxt.pin_val[i] = 1'b0;
					q_nxt.pin_oe[i]  = ~v;
				end else begin
					q_nxt.pin_val[i] = v;
					q_nxt.pin_oe[i]  = 1'b1;
				end
			end else begin
				q_nxt.lvl[i]     = q_r.db[i] ^ q_r.inv[i];
				q_nxt.pin_val[i] = 1'b0;
				q_nxt.pin_oe[i]  = 1'b0;
			end
			// rail switching is slow in the pad; here it is a level
			q_nxt.rail_on[i] = q_r.rail[i] & RAIL_CAPABLE[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r          <= '0;
			q_r.dir      <= DIR_RST;
			q_r.src      <= {NLINES{SRC_RST}};
			q_r.exp_mode <= EXP_MODE_RST;
			q_r.uout     <= USER_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

endmodule : camera_digital_io_lines

`default_nettype wire

// ===== hdl/gpio_lines_pkg.sv
package gpio_lines_pkg;

	localparam int NLINES = 4;
	localparam int NUSER  = 4;

	// clock rate and filter timing
	localparam int CLK_MHZ   = 125;
	localparam int US_PER_US = 1;
	localparam int CYC_W     = 39;
	localparam logic [CYC_W-1:0] CYC_PER_US =
		CYC_W'(CLK_MHZ * US_PER_US);

	// register byte addresses
	localparam logic [7:0] ADDR_LINE_SEL   = 8'h00;
	localparam logic [7:0] ADDR_LINE_DIR   = 8'h04;
	localparam logic [7:0] ADDR_RAIL_EN    = 8'h08;
	localparam logic [7:0] ADDR_INVERT     = 8'h0C;
	localparam logic [7:0] ADDR_LEVEL      = 8'h10;
	localparam logic [7:0] ADDR_ALL_LEVELS = 8'h14;
	localparam logic [7:0] ADDR_FILT_KIND  = 8'h18;
	localparam logic [7:0] ADDR_FILT_WIDTH = 8'h1C;
	localparam logic [7:0] ADDR_OUT_SRC    = 8'h20;
	localparam logic [7:0] ADDR_CIRCUIT    = 8'h24;
	localparam logic [7:0] ADDR_EXP_MODE   = 8'h28;
	localparam logic [7:0] ADDR_USER_SEL   = 8'h2C;
	localparam logic [7:0] ADDR_USER_VAL   = 8'h30;
	localparam logic [7:0] ADDR_USER_ALL   = 8'h34;

	typedef enum logic [4:0] {
		SRC_OFF      = 5'h00,
		SRC_LINE0    = 5'h01,
		SRC_LINE1    = 5'h02,
		SRC_LINE2    = 5'h03,
		SRC_LINE3    = 5'h04,
		SRC_USER0    = 5'h05,
		SRC_USER1    = 5'h06,
		SRC_USER2    = 5'h07,
		SRC_USER3    = 5'h08,
		SRC_CNT0_ACT = 5'h09,
		SRC_CNT1_ACT = 5'h0A,
		SRC_LOGIC0   = 5'h0B,
		SRC_LOGIC1   = 5'h0C,
		SRC_EXPOSING = 5'h0D,
		SRC_TRIG_RDY = 5'h0E,
		SRC_PPS      = 5'h0F,
		SRC_SERIAL0  = 5'h10
	} src_e;

	typedef enum logic {
		DIR_INPUT  = 1'b0,
		DIR_OUTPUT = 1'b1
	} dir_e;

	typedef enum logic {
		FILT_DEGLITCH = 1'b0,
		FILT_DEBOUNCE = 1'b1
	} filt_e;

	typedef enum logic [1:0] {
		CT_TRISTATE   = 2'h0,
		CT_OPTO       = 2'h1,
		CT_OPEN_DRAIN = 2'h2
	} circuit_e;

	typedef enum logic [1:0] {
		EXP_LINE1      = 2'h0,
		EXP_ANY_PIXELS = 2'h1,
		EXP_ALL_PIXELS = 2'h2
	} exp_mode_e;

	// per-line wiring facts: line 2 alone carries the power rail
	localparam logic [3:0] RAIL_CAPABLE = 4'h4;
	// circuit type per line, line 3 in the top two bits
	localparam logic [7:0] CIRCUIT_MAP  = 8'h25;

	// reset values
	localparam logic [3:0] DIR_RST      = 4'h0;
	localparam logic [4:0] SRC_RST      = 5'h00;
	localparam logic [1:0] EXP_MODE_RST = 2'h0;
	localparam logic [3:0] USER_RST     = 4'h0;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic [1:0] counter_active;
		logic [1:0] logic_block_out;
		logic       exposing;
		logic       trigger_ready;
		logic       pps;
		logic       serial_tx;
	} int_src_s;

	typedef struct packed {
		logic [1:0]             sel;
		logic [3:0]             dir;
		logic [3:0]             rail;
		logic [3:0]             inv;
		logic [3:0]             fkind;
		logic [3:0][31:0]       wdg;
		logic [3:0][31:0]       wdb;
		logic [3:0][4:0]        src;
		logic [1:0]             exp_mode;
		logic [1:0]             usel;
		logic [3:0]             uout;
		logic [3:0]             s1;
		logic [3:0]             s2;
		logic [3:0]             s3;
		logic [3:0]             syn;
		logic [3:0]             dg;
		logic [3:0][CYC_W-1:0]  dgc;
		logic [3:0]             db;
		logic [3:0][CYC_W-1:0]  dbc;
		logic [3:0]             lvl;
		logic [3:0]             pin_val;
		logic [3:0]             pin_oe;
		logic [3:0]             rail_on;
		logic [31:0]            rdata;
	} state_s;

	function automatic logic [CYC_W-1:0] us_to_cyc(
		input logic [31:0] us
	);
		us_to_cyc = CYC_W'({7'h00, us} * CYC_PER_US);
	endfunction : us_to_cyc

endpackage : gpio_lines_pkg

// ===== verification/camera_digital_io_lines_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module io_lines_checker
	import gpio_lines_pkg::*;
(
	// watched ports
	input wire logic       pclk,
	input wire logic       presetn,
	input wire apb_req_s   apb_req,
	input wire apb_rsp_s   apb_rsp,
	input wire logic [3:0] line_out,
	input wire logic [3:0] line_oe,
	input wire logic [3:0] rail_enable
);
	logic [1:0] sel_r;
	logic       dir_r;
	logic       acc;
	logic       rd;
	logic       wr_dir;
	assign acc = apb_req.psel && apb_req.penable;
	assign rd = acc && !apb_req.pwrite;
	assign wr_dir = acc && apb_req.pwrite && apb_req.paddr == ADDR_LINE_DIR;
	// mirror selector and direction so checks know the addressed line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r <= 2'h0;
			dir_r <= 1'b0;
		end else if (acc && apb_req.pwrite) begin
			if (apb_req.paddr == ADDR_LINE_SEL)
				sel_r <= apb_req.pwdata[1:0];
			if (apb_req.paddr == ADDR_LINE_DIR)
				dir_r <= apb_req.pwdata[0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rail_capable: assert property (~|(rail_enable & ~RAIL_CAPABLE))
		else $error("rail on a line without rail");
	a_drain_low: assert property (!line_out[2])
		else $error("open drain line driven high");
	a_circuit_read: assert property (rd && apb_req.paddr == ADDR_CIRCUIT
		|-> apb_rsp.prdata == 32'(CIRCUIT_MAP[2*sel_r+:2]))
		else $error("circuit type mismatch");
	a_level_bit: assert property (rd && apb_req.paddr == ADDR_LEVEL
		|-> apb_rsp.prdata[31:1] == 31'h0)
		else $error("level readback too wide");
	a_all_levels: assert property (rd && apb_req.paddr == ADDR_ALL_LEVELS
		|-> apb_rsp.prdata[31:4] == 28'h0)
		else $error("level word too wide");
	a_user_word: assert property (rd && apb_req.paddr == ADDR_USER_ALL
		|-> apb_rsp.prdata[31:4] == 28'h0)
		else $error("user word too wide");
	// line 2 is open drain, its enable follows the value instead
	a_dir_to_oe: assert property (wr_dir && sel_r != 2'h2
		|-> ##[1:3] line_oe[sel_r] == dir_r)
		else $error("enable does not follow direction");
	// misaligned offsets are refused as well as those past the map
	a_bad_addr: assert property (acc
		&& (apb_req.paddr > ADDR_USER_ALL || apb_req.paddr[1:0] != 2'h0)
		|-> apb_rsp.pslverr)
		else $error("no error on unmapped address");
endmodule : io_lines_checker
bind camera_digital_io_lines io_lines_checker u_chk (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.line_out(line_out), .line_oe(line_oe), .rail_enable(rail_enable)
);
`default_nettype wire

// ===== verification/camera_digital_io_lines_tb.sv
`timescale 1ns/1ns
`default_nettype none
module camera_digital_io_lines_tb
	import gpio_lines_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	apb_req_s    req = '0;
	apb_rsp_s    rsp;
	int_src_s    isrc = '0;
	logic [3:0]  ext = 4'h0;
	logic [3:0]  lin, lout, loe, rail;
	logic [1:0]  emode;
	logic [31:0] rdat;
	logic        err;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	always #4 pclk = ~pclk;
	camera_digital_io_lines dut (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .int_src(isrc), .line_in(lin),
		.line_out(lout), .line_oe(loe), .rail_enable(rail),
		.exposure_mode(emode));
	io_connector_model far (.line_out(lout), .line_oe(loe),
		.ext_drive(ext), .line_in(lin));
	task end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd
	// bounded wait, the path runs through the input synchroniser
	task wait_out(input int i, input logic v);
		int n;
		n = 0;
		while (lout[i] !== v && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(lout[i]), 32'(v));
	endtask : wait_out
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LINE_SEL, 32'(i));
			rd(ADDR_CIRCUIT, 32'(CIRCUIT_MAP[2*i+:2]));
			rd(ADDR_LINE_DIR, 32'h0);
			wr(ADDR_RAIL_EN, 32'h1);
			rd(ADDR_RAIL_EN, 32'(RAIL_CAPABLE[i]));
		end
		chk(32'(rail), 32'h4);
		rd(ADDR_USER_ALL, 32'h0);
	endtask : t_reset
	task t_levels;
		ext <= 4'hA;
		repeat (8) @(posedge pclk);
		rd(ADDR_ALL_LEVELS, 32'hA);
		wr(ADDR_LINE_SEL, 32'h1);
		rd(ADDR_LEVEL, 32'h1);
		wr(ADDR_LINE_SEL, 32'h0);
		rd(ADDR_LEVEL, 32'h0);
		wr(ADDR_INVERT, 32'h1);
		rd(ADDR_LEVEL, 32'h1);
		wr(ADDR_INVERT, 32'h0);
		wr(ADDR_ALL_LEVELS, 32'h0);
		rd(ADDR_ALL_LEVELS, 32'hA);
	endtask : t_levels
	task t_user;
		wr(ADDR_LINE_DIR, 32'h1);
		wr(ADDR_OUT_SRC, 32'(SRC_USER2));
		wr(ADDR_USER_SEL, 32'h2);
		wr(ADDR_USER_VAL, 32'h1);
		wait_out(0, 1'b1);
		rd(ADDR_USER_ALL, 32'h4);
		wr(ADDR_USER_ALL, 32'hB);
		wait_out(0, 1'b0);
		rd(ADDR_USER_VAL, 32'h0);
		wr(ADDR_INVERT, 32'h1);
		wait_out(0, 1'b1);
		wr(ADDR_INVERT, 32'h0);
	endtask : t_user
	task t_sources;
		int pos [8];
		pos = '{6, 7, 4, 5, 3, 2, 1, 0};
		wr(ADDR_LINE_SEL, 32'h3);
		wr(ADDR_LINE_DIR, 32'h1);
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_OUT_SRC, 32'(k + 9));
			isrc <= int_src_s'(8'h01 << pos[k]);
			wait_out(3, 1'b1);
			isrc <= int_src_s'(~(8'h01 << pos[k]));
			wait_out(3, 1'b0);
		end
		wr(ADDR_OUT_SRC, 32'(SRC_LINE1));
		ext <= 4'h2;
		wait_out(3, 1'b1);
		ext <= 4'h0;
		wait_out(3, 1'b0);
	endtask : t_sources
	task t_deglitch;
		wr(ADDR_LINE_SEL, 32'h0);
		wr(ADDR_LINE_DIR, 32'h0);
		wr(ADDR_FILT_KIND, 32'h0);
		wr(ADDR_FILT_WIDTH, 32'h1);
		ext <= 4'h1;
		repeat (60) @(posedge pclk);
		ext <= 4'h0;
		repeat (150) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h0);
		ext <= 4'h1;
		repeat (100) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h0);
		repeat (60) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h1);
	endtask : t_deglitch
	task t_debounce;
		wr(ADDR_LINE_SEL, 32'h1);
		wr(ADDR_FILT_KIND, 32'h1);
		wr(ADDR_FILT_WIDTH, 32'h1);
		ext <= 4'h3;
		repeat (10) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h1);
		ext <= 4'h1;
		repeat (20) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h1);
		repeat (150) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h0);
	endtask : t_debounce
	// line 1 still selected, debounce kind, debounce width 1 us
	task t_config;
		wr(ADDR_EXP_MODE, 32'(EXP_ALL_PIXELS));
		rd(ADDR_EXP_MODE, 32'(EXP_ALL_PIXELS));
		chk(32'(emode), 32'(EXP_ALL_PIXELS));
		rd(ADDR_FILT_WIDTH, 32'h1);
		wr(ADDR_FILT_KIND, 32'h0);
		rd(ADDR_FILT_WIDTH, 32'h0);
		wr(ADDR_FILT_WIDTH, 32'h5);
		wr(ADDR_FILT_KIND, 32'h1);
		rd(ADDR_FILT_WIDTH, 32'h1);
		wr(ADDR_FILT_KIND, 32'h0);
		rd(ADDR_FILT_WIDTH, 32'h5);
		wr(ADDR_OUT_SRC, 32'(SRC_USER0));
		repeat (2) @(posedge pclk);
		chk(32'({loe[1], lout[1]}), 32'h0);
		wr(ADDR_LINE_DIR, 32'h1);
		wait_out(1, 1'b1);
		wr(ADDR_LINE_DIR, 32'h0);
	endtask : t_config
	// a longer debounce than deglitch tells the stage order apart
	task t_sampled;
		wr(ADDR_LINE_SEL, 32'h0);
		rd(ADDR_LEVEL, 32'h1);
		ext <= 4'h0;
		repeat (200) @(posedge pclk);
		chk(rsp.prdata, 32'h1);
		rd(ADDR_LEVEL, 32'h0);
		wr(ADDR_FILT_KIND, 32'h1);
		wr(ADDR_FILT_WIDTH, 32'h2);
		ext <= 4'h1;
		repeat (60) @(posedge pclk);
		ext <= 4'h0;
		repeat (140) @(posedge pclk);
		rd(ADDR_LEVEL, 32'h0);
	endtask : t_sampled
	task t_drain;
		wr(ADDR_LINE_SEL, 32'h2);
		wr(ADDR_LINE_DIR, 32'h1);
		wr(ADDR_OUT_SRC, 32'(SRC_USER0));
		repeat (2) @(posedge pclk);
		chk(32'({loe[2], lout[2]}), 32'h0);
		rd(ADDR_LEVEL, 32'h1);
		wr(ADDR_USER_ALL, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'({loe[2], lout[2]}), 32'h2);
		rd(ADDR_LEVEL, 32'h0);
	endtask : t_drain
	task t_bad_addr;
		apb(1'b0, 8'h3C, 32'h0);
		chk(32'(err), 32'h1);
		chk(rdat, 32'h0);
		apb(1'b1, 8'h02, 32'h3);
		chk(32'(err), 32'h1);
		rd(ADDR_LINE_SEL, 32'h2);
	endtask : t_bad_addr
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_levels;
		t_user;
		t_sources;
		t_deglitch;
		t_debounce;
		t_config;
		t_sampled;
		t_drain;
		t_bad_addr;
		end_sim;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			end_sim;
		end
	end
endmodule : camera_digital_io_lines_tb
`default_nettype wire

// ===== verification/io_connector_model.sv
`timescale 1ns/1ns
`default_nettype none
module io_connector_model (
	// design drive
	input wire logic [3:0] line_out,
	input wire logic [3:0] line_oe,
	// far-side circuit levels, pull-up included
	input wire logic [3:0] ext_drive,
	// pin levels seen by the design
	output logic     [3:0] line_in
);
	// a driving pin wins; open drain drives 0 so it only ever pulls low
	assign line_in = (line_oe & line_out) | (~line_oe & ext_drive);
endmodule : io_connector_model
`default_nettype wire
